/* File: common/hsq_map.vh */
// constants for the homing sequencer: method codes, control word values, phases
`ifndef HSQ_MAP_VH
`define HSQ_MAP_VH
`define HSQ_METHOD_SWITCH_REV   8'h1E
`define HSQ_METHOD_INDEX_REV    8'h21
`define HSQ_METHOD_INDEX_FWD    8'h22
`define HSQ_METHOD_HERE         8'h23
`define HSQ_CW_READY            16'h000F
`define HSQ_CW_START            16'h001F
`define HSQ_OFFSET_ABSOLUTE     1'b0
`define HSQ_OFFSET_RELATIVE     1'b1
`define HSQ_SPEED_W             16
`define HSQ_POS_W               32
`define HSQ_ST_IDLE             3'h0
`define HSQ_ST_FAST_REV         3'h1
`define HSQ_ST_FAST_FWD         3'h2
`define HSQ_ST_SLOW_REV         3'h3
`define HSQ_ST_INDEX            3'h4
`define HSQ_ST_DONE             3'h5
`define HSQ_ST_ERROR            3'h6
`endif

/* File: hw/hsq_sync.v */
// two-stage synchroniser with edge detection for asynchronous pins
`timescale 1ns/1ns
module hsq_sync #(
    parameter WIDTH = 4
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out,
    output wire [WIDTH-1:0] rise,
    output wire [WIDTH-1:0] fall
);
    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] prev;

    // meta feeds only sync_out; edges are taken after the second stage
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            meta     <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
            prev     <= {WIDTH{1'b0}};
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
            prev     <= sync_out;
        end
    end

    assign rise = sync_out & ~prev;
    assign fall = ~sync_out & prev;
endmodule // hsq_sync

/* File: hw/hsq_homing.v */
// homing sequencer for methods 30, 33, 34 and 35
`timescale 1ns/1ns
`include "hsq_map.vh"
module hsq_homing #(
    parameter SPEED_W = `HSQ_SPEED_W,
    parameter POS_W   = `HSQ_POS_W
) (
    input  wire               ref_clk,
    input  wire               rst,
    input  wire [15:0]        control_word,
    input  wire [7:0]         homing_method_select,
    input  wire               homing_offset_mode,
    input  wire [POS_W-1:0]   origin_offset_value,
    input  wire [SPEED_W-1:0] high_speed,
    input  wire [SPEED_W-1:0] low_speed,
    input  wire [POS_W-1:0]   position_in,
    input  wire               origin_switch_input,
    input  wire               reverse_limit,
    input  wire               forward_limit,
    input  wire               index_pulse,
    output reg  [SPEED_W-1:0] speed_cmd,
    output reg                move_reverse,
    output reg                moving,
    output reg                homing_done,
    output reg                homing_error,
    output reg                position_load,
    output reg  [POS_W-1:0]   position_feedback_value
);
    // --------------------------------------------------------------
    // input synchronisers
    // --------------------------------------------------------------
    wire [3:0] pin_sync;
    wire [3:0] pin_rise;
    wire [3:0] pin_fall;

    hsq_sync #(
        .WIDTH (4)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in ({index_pulse, forward_limit, reverse_limit, origin_switch_input}),
        .sync_out (pin_sync),
        .rise     (pin_rise),
        .fall     (pin_fall)
    );

    wire sw_level = pin_sync[0];
    wire sw_rise  = pin_rise[0];
    wire sw_fall  = pin_fall[0];
    wire rev_lim  = pin_sync[1];
    wire fwd_lim  = pin_sync[2];
    wire idx_rise = pin_rise[3];

    // --------------------------------------------------------------
    // phase codes and start decode
    // --------------------------------------------------------------
    localparam [2:0] ST_IDLE     = `HSQ_ST_IDLE;
    localparam [2:0] ST_FAST_REV = `HSQ_ST_FAST_REV;
    localparam [2:0] ST_FAST_FWD = `HSQ_ST_FAST_FWD;
    localparam [2:0] ST_SLOW_REV = `HSQ_ST_SLOW_REV;
    localparam [2:0] ST_INDEX    = `HSQ_ST_INDEX;
    localparam [2:0] ST_DONE     = `HSQ_ST_DONE;
    localparam [2:0] ST_ERROR    = `HSQ_ST_ERROR;

    // first phase of a search from the method value and the switch level; an unknown method goes to error
    function [2:0] first_phase;
        input [7:0] method;
        input       level;
        begin
            case (method)
                `HSQ_METHOD_SWITCH_REV:
                    first_phase = level ? ST_SLOW_REV
                                        : ST_FAST_REV;
                `HSQ_METHOD_INDEX_REV: first_phase = ST_INDEX;
                `HSQ_METHOD_INDEX_FWD: first_phase = ST_INDEX;
                `HSQ_METHOD_HERE:      first_phase = ST_DONE;
                default:               first_phase = ST_ERROR;
            endcase
        end
    endfunction

    reg  [15:0] cw_prev;
    reg  [2:0]  state;
    reg  [2:0]  next_state;

    // start is the step of the control word from ready to start
    wire        start    = (cw_prev == `HSQ_CW_READY) && (control_word == `HSQ_CW_START);
    // a start given during motion is dropped; status and origin are left alone then
    wire        at_rest  = (state == ST_IDLE) || (state == ST_DONE) || (state == ST_ERROR);
    wire        accept   = start && at_rest;
    wire [2:0]  entry    = first_phase(homing_method_select, sw_level);
    wire        load_org = accept && (entry == ST_DONE);
    // a run that ends where the last one ended must still raise its flag
    wire        set_done = (next_state == ST_DONE) && ((state != ST_DONE) || accept);
    wire        set_err  = (next_state == ST_ERROR) && ((state != ST_ERROR) || accept);

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    // next phase from the present one and the synchronised pin events
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE, ST_DONE, ST_ERROR:
            begin
                if (accept)
                    next_state = entry;
            end
            ST_FAST_REV:
            begin
                if (sw_rise)
                    next_state = ST_SLOW_REV;
                else if (rev_lim)
                    next_state = ST_FAST_FWD;
            end
            ST_FAST_FWD:
            begin
                if (sw_rise)
                    next_state = ST_SLOW_REV;
                else if (fwd_lim)
                    next_state = ST_ERROR;    // switch never found
            end
            ST_SLOW_REV:
            begin
                if (sw_fall)
                    next_state = ST_DONE;
                else if (rev_lim)
                    next_state = ST_ERROR;
            end
            ST_INDEX:
            begin
                if (idx_rise)
                    next_state = ST_DONE;
                else if (move_reverse ? rev_lim : fwd_lim)
                    next_state = ST_ERROR;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // motion outputs follow the phase; every output is registered
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cw_prev                 <= 16'h0000;
            state                   <= ST_IDLE;
            speed_cmd               <= {SPEED_W{1'b0}};
            move_reverse            <= 1'b0;
            moving                  <= 1'b0;
            homing_done             <= 1'b0;
            homing_error            <= 1'b0;
            position_load           <= 1'b0;
            position_feedback_value <= {POS_W{1'b0}};
        end
        else
        begin
            cw_prev       <= control_word;
            state         <= next_state;
            position_load <= 1'b0;
            case (next_state)
                ST_FAST_REV:
                begin
                    speed_cmd    <= high_speed;
                    move_reverse <= 1'b1;
                    moving       <= 1'b1;
                end
                ST_FAST_FWD:
                begin
                    speed_cmd    <= high_speed;
                    move_reverse <= 1'b0;
                    moving       <= 1'b1;
                end
                ST_SLOW_REV:
                begin
                    speed_cmd    <= low_speed;
                    move_reverse <= 1'b1;
                    moving       <= 1'b1;
                end
                ST_INDEX:
                begin
                    speed_cmd    <= low_speed;
                    moving       <= 1'b1;
                    // direction is fixed on entry and held through the search
                    if (state != ST_INDEX)
                        move_reverse <= (homing_method_select == `HSQ_METHOD_INDEX_REV);
                end
                default:
                begin
                    speed_cmd <= {SPEED_W{1'b0}};
                    moving    <= 1'b0;
                end
            endcase
            // status: cleared on an accepted start, set on entry to done or error; set wins
            if (set_done)
                homing_done <= 1'b1;
            else if (accept)
                homing_done <= 1'b0;
            if (set_err)
                homing_error <= 1'b1;
            else if (accept)
                homing_error <= 1'b0;
            // tracks external position except in the cycle of an origin load
            if (load_org)
            begin
                position_load <= 1'b1;
                if (homing_offset_mode == `HSQ_OFFSET_RELATIVE)
                    position_feedback_value <= position_in + origin_offset_value;
                else
                    position_feedback_value <= origin_offset_value;
            end
            else
                position_feedback_value <= position_in;
        end
    end
endmodule // hsq_homing

/* File: verif/hsq_homing_asserts.sv */
// concurrent checks on the homing sequencer ports
`timescale 1ns/1ns
`include "hsq_map.vh"
module hsq_homing_asserts (
    input wire        ref_clk,
    input wire        rst,
    input wire [15:0] control_word,
    input wire [7:0]  homing_method_select,
    input wire        homing_offset_mode,
    input wire [31:0] origin_offset_value,
    input wire [15:0] low_speed,
    input wire [31:0] position_in,
    input wire [15:0] speed_cmd,
    input wire        move_reverse,
    input wire        moving,
    input wire        homing_done,
    input wire        homing_error,
    input wire        position_load,
    input wire [31:0] position_feedback_value
);
    reg  [15:0] cw_q;
    wire [7:0]  m = homing_method_select;
    // a start is the ready-to-start step of the control word while no search runs
    wire        st = cw_q == `HSQ_CW_READY && control_word == `HSQ_CW_START && !moving;
    always @(posedge ref_clk or posedge rst)
        cw_q <= rst ? 16'h0000 : control_word;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_rev_index_start: assert property (st && m == `HSQ_METHOD_INDEX_REV |=> moving && move_reverse
        && speed_cmd == $past(low_speed)) else $error("index reverse start wrong");
    chk_fwd_index_start: assert property (st && m == `HSQ_METHOD_INDEX_FWD |=> moving && !move_reverse
        && speed_cmd == $past(low_speed)) else $error("index forward start wrong");
    chk_here_done: assert property (st && m == `HSQ_METHOD_HERE |=> homing_done && position_load && !moving)
        else $error("here method did not complete");
    chk_abs_load: assert property (st && m == `HSQ_METHOD_HERE && !homing_offset_mode
        |=> position_feedback_value == $past(origin_offset_value)) else $error("absolute load wrong");
    chk_rel_load: assert property (st && m == `HSQ_METHOD_HERE && homing_offset_mode
        |=> position_feedback_value == $past(position_in) + $past(origin_offset_value))
        else $error("relative load wrong");
    chk_load_pulse: assert property (position_load |=> !position_load) else $error("load longer than one cycle");
    chk_idle_speed: assert property (!moving |-> speed_cmd == 16'h0000) else $error("speed while stopped");
    chk_bad_method: assert property (st && !(m inside {8'h1E, 8'h21, 8'h22, 8'h23})
        |=> homing_error && !moving) else $error("unknown method accepted");
    chk_stop_flag: assert property ($fell(moving) |-> homing_done || homing_error)
        else $error("stopped without status");
endmodule // hsq_homing_asserts

/* File: verif/hsq_axis_model.sv */
// axis model: position counter, origin switch window, limits and index marks
`timescale 1ns/1ns
module hsq_axis_model (
    input  wire        ref_clk,
    input  wire        moving,
    input  wire        move_reverse,
    input  wire        load,
    input  wire [31:0] load_pos,
    output wire [31:0] position_in,
    output wire        origin_switch_input,
    output wire        reverse_limit,
    output wire        forward_limit,
    output wire        index_pulse
);
    reg signed [31:0] pos = 0;
    // one count a cycle at either speed: only the order of events is judged
    always @(posedge ref_clk)
        pos <= load ? load_pos : !moving ? pos : move_reverse ? pos - 1 : pos + 1;
    assign position_in         = pos;
    assign origin_switch_input = pos >= 100 && pos <= 150;
    assign reverse_limit       = pos <= 0;
    assign forward_limit       = pos >= 1000;
    assign index_pulse         = pos[5:0] == 6'h00 && moving;
endmodule // hsq_axis_model

/* File: verif/hsq_homing_tb.sv */
// self-checking bench for the homing sequencer
`timescale 1ns/1ns
`include "hsq_map.vh"
module hsq_homing_tb;
    reg         ref_clk = 0, rst = 1, omode = 0, load = 0;
    reg  [15:0] cw = 0, hs = 0, ls = 0;
    reg  [7:0]  msel = 0;
    reg  [31:0] ooff = 0, lpos = 0, fb_seen;
    wire [31:0] pin, pfb;
    wire [15:0] spd;
    wire        osw, rlim, flim, idx, rev, mov, done, err, pld;
    integer     fails = 0, checks_done = 0, seed = 52102, cyc = 0;
    reg         saw_fast, saw_fwd, bad_spd, ld_seen;
    always #20 ref_clk = ~ref_clk;
    hsq_homing u_hsq_homing (.ref_clk(ref_clk), .rst(rst), .control_word(cw), .homing_method_select(msel),
        .homing_offset_mode(omode), .origin_offset_value(ooff), .high_speed(hs), .low_speed(ls),
        .position_in(pin), .origin_switch_input(osw), .reverse_limit(rlim), .forward_limit(flim),
        .index_pulse(idx), .speed_cmd(spd), .move_reverse(rev), .moving(mov), .homing_done(done),
        .homing_error(err), .position_load(pld), .position_feedback_value(pfb));
    hsq_axis_model u_hsq_axis_model (.ref_clk(ref_clk), .moving(mov), .move_reverse(rev), .load(load),
        .load_pos(lpos), .position_in(pin), .origin_switch_input(osw), .reverse_limit(rlim),
        .forward_limit(flim), .index_pulse(idx));
    // watch speed and direction during every search, away from the launching edge
    always @(negedge ref_clk)
    begin
        cyc = cyc + 1;
        if (mov === 1'b1)
        begin
            saw_fast = saw_fast | (spd === hs);
            saw_fwd  = saw_fwd | (rev === 1'b0);
            bad_spd  = bad_spd | (spd !== hs && spd !== ls);
        end
        if (cyc == 20000)
        begin
            fails = fails + 1;
            give_verdict;
        end
    end
    task chk(input bit ok, input string msg);
        checks_done = checks_done + 1;
        if (!ok)
        begin
            fails = fails + 1;
            $display("mismatch at %0t: %0s", $time, msg);
        end
    endtask
    task give_verdict;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // place the axis, give ready then start, wait for the stop, judge the resting place
    task run(input [7:0] m, input integer p, input integer lo, input integer hi, input bit md);
        integer n;
        @(negedge ref_clk);
        {load, lpos, msel, omode, cw} = {1'b1, p, m, md, `HSQ_CW_READY};
        hs   = $random(seed) | 16'h8000;
        ls   = $random(seed) & 16'h7FFF | 16'h0001;
        ooff = $random(seed);
        {saw_fast, saw_fwd, bad_spd} = 3'b000;
        repeat (4) @(negedge ref_clk) load = 0;
        cw = `HSQ_CW_START;
        @(negedge ref_clk) {ld_seen, fb_seen, cw} = {pld, pfb, `HSQ_CW_READY};
        for (n = 0; n < 3000 && mov === 1'b1; n = n + 1) @(negedge ref_clk);
        chk((m inside {8'h1E, 8'h21, 8'h22, 8'h23} ? done : err) === 1'b1, "final status");
        chk($signed(pin) >= lo && $signed(pin) <= hi && bad_spd === 1'b0, "stop place or speed");
        $display("test method %0d from %0d done", m, p);
    endtask
    initial
    begin
        repeat (8) @(negedge ref_clk);
        rst = 0;
        chk({mov, done, err, pld, spd} === 20'h00000, "reset outputs");
        run(`HSQ_METHOD_SWITCH_REV, 200, 92, 99, 0);
        chk(saw_fast === 1'b1 && saw_fwd === 1'b0, "plain switch search");
        run(`HSQ_METHOD_SWITCH_REV, 50, 92, 99, 0);
        chk(saw_fwd === 1'b1 && saw_fast === 1'b1, "limit reversal");
        run(`HSQ_METHOD_SWITCH_REV, 120, 92, 99, 0);
        chk(saw_fast === 1'b0 && saw_fwd === 1'b0, "start on switch");
        run(`HSQ_METHOD_INDEX_REV, 200, 184, 191, 0);
        chk(saw_fwd === 1'b0 && saw_fast === 1'b0, "index reverse");
        run(`HSQ_METHOD_INDEX_FWD, 200, 257, 263, 0);
        chk(saw_fwd === 1'b1 && saw_fast === 1'b0, "index forward");
        run(`HSQ_METHOD_HERE, 77, 77, 77, 0);
        chk(ld_seen === 1'b1 && fb_seen === ooff, "absolute origin");
        run(`HSQ_METHOD_HERE, 77, 77, 77, 1);
        chk(ld_seen === 1'b1 && fb_seen === 32'd77 + ooff, "relative origin");
        run(8'h40 | $random(seed), 300, 300, 300, 0);
        give_verdict;
    end
endmodule // hsq_homing_tb
bind hsq_homing hsq_homing_asserts u_hsq_homing_asserts (.*);
